// [rtl/pitb_pkg.sv]
// Purpose : Shared constants for the peripheral interrupt and time base
// Assumes : Byte-wide register port, seven request sources
// Notes   : Source index order is also the service priority order

package pitb_pkg;

   // ***********************************
   // Register offsets
   // ***********************************
   localparam logic [7:0] ADDR_PSC = 8'h00;
   localparam logic [7:0] ADDR_TB0 = 8'h01;
   localparam logic [7:0] ADDR_TB1 = 8'h02;
   localparam logic [7:0] ADDR_IEN = 8'h03;
   localparam logic [7:0] ADDR_IFL = 8'h04;
   localparam logic [7:0] ADDR_VST = 8'h05;

   // ***********************************
   // Reset values and fields
   // ***********************************
   localparam logic [7:0] PSC_RST  = 8'h00;
   localparam logic [7:0] TBC_RST  = 8'h00;
   localparam logic [7:0] IEN_RST  = 8'h00;
   localparam logic [6:0] IFL_RST  = 7'h00;
   localparam int unsigned TBC_RUN_BIT = 7;
   localparam int unsigned IEN_GIE_BIT = 7;
   localparam int unsigned PER_W       = 3;
   localparam int unsigned PSC_SEL_W   = 2;
   localparam int unsigned PERIOD_BASE_EXP = 8;
   localparam logic [1:0]  PSC_SYS     = 2'h0;
   localparam logic [1:0]  PSC_DIV4    = 2'h1;

   // ***********************************
   // Sources, lowest index served first
   // ***********************************
   localparam int unsigned NSRC       = 7;
   localparam int unsigned SRC_CONV   = 0;
   localparam int unsigned SRC_TICK0  = 1;
   localparam int unsigned SRC_TICK1  = 2;
   localparam int unsigned SRC_SERIAL = 3;
   localparam int unsigned SRC_LOWV   = 4;
   localparam int unsigned SRC_EEPROM = 5;
   localparam int unsigned SRC_UART   = 6;
   localparam logic [11:0] VEC_BASE   = 12'h004;
   localparam logic [11:0] VEC_STEP   = 12'h004;

endpackage

// [rtl/pitb_prescale.sv]
// Purpose : Prescaled clock enable for both time bases
// Assumes : Sub clock is a level input synchronous to core_clk
// Notes   : Output is a one-cycle enable, never a clock

`timescale 1ns/1ps
`default_nettype none

module pitb_prescale
   import pitb_pkg::*;
(
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rstn,
   // Control
   input  wire logic [PSC_SEL_W-1:0] src_sel,
   input  wire logic                 sub_clk,
   // Enable out
   output logic                      psc_tick
);

   logic [1:0] div_q;
   logic       sub_q;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         div_q <= 2'h0;
         sub_q <= 1'b0;
      end else begin
         div_q <= div_q + 2'h1;
         sub_q <= sub_clk;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         psc_tick <= 1'b0;
      end else if (src_sel == PSC_SYS) begin
         psc_tick <= 1'b1;
      end else if (src_sel == PSC_DIV4) begin
         psc_tick <= (div_q == 2'h3);
      end else begin
         psc_tick <= sub_clk & ~sub_q;
      end
   end

   property p_sys_rate;
      @(posedge core_clk) disable iff (!rstn)
      (src_sel == PSC_SYS) |=> psc_tick;
   endproperty
   a_sys_rate: assert property (p_sys_rate)
      else $error("system clock source gave no tick");

endmodule // pitb_prescale

`default_nettype wire

// [rtl/pitb_tick.sv]
// Purpose : One time base divider with periodic overflow pulse
// Assumes : psc_tick is a one-cycle enable
// Notes   : Stopping clears the count, so a restart gives a full period

`timescale 1ns/1ps
`default_nettype none

module pitb_tick
   import pitb_pkg::*;
#(
   parameter int unsigned CNT_W = 15
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rstn,
   // Control
   input  wire logic             run,
   input  wire logic [PER_W-1:0] period_sel,
   input  wire logic             psc_tick,
   // Event out
   output logic                  ovf
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] limit;
   logic             wrap;

   // period is two to the eight plus code
   assign limit = CNT_W'((32'd1 << (PERIOD_BASE_EXP + 32'(period_sel)))
                         - 32'd1);
   // Compare with >= so a shorter period picked mid-count still wraps
   assign wrap  = (cnt_q >= limit);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= '0;
      end else if (!run) begin
         cnt_q <= '0;
      end else if (psc_tick) begin
         cnt_q <= wrap ? '0 : cnt_q + CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ovf <= 1'b0;
      end else begin
         ovf <= run & psc_tick & wrap;
      end
   end

   property p_stop;
      @(posedge core_clk) disable iff (!rstn)
      ovf |-> $past(run) && $past(psc_tick);
   endproperty
   a_stop: assert property (p_stop)
      else $error("overflow while stopped");

   property p_period;
      @(posedge core_clk) disable iff (!rstn)
      ovf |-> $past(cnt_q) == $past(limit) || $past(cnt_q) > $past(limit);
   endproperty
   a_period: assert property (p_period)
      else $error("overflow before period end");

endmodule // pitb_tick

`default_nettype wire

// [rtl/pitb_top.sv]
// Purpose : Request flags, enables, vectoring and two time bases
// Assumes : CPU pulses irq_ack for one cycle to take the shown vector
// Notes   : Plain return needs no input; the global enable stays clear

`timescale 1ns/1ps
`default_nettype none

module pitb_top
   import pitb_pkg::*;
#(
   parameter int unsigned CNT_W = 15
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Peripheral events, one-cycle pulses
   input  wire logic        conv_done_evt,
   input  wire logic        serial_if_byte_evt,
   input  wire logic        serial_if_match_evt,
   input  wire logic        serial_if_tmo_evt,
   input  wire logic        low_supply_evt,
   input  wire logic        eeprom_write_end_evt,
   input  wire logic [5:0]  async_serial_evt,
   // Sub clock level
   input  wire logic        sub_clk,
   // CPU side
   input  wire logic        stack_full,
   input  wire logic        irq_ack,
   input  wire logic        reti_exec,
   output logic             irq_req,
   output logic      [11:0] irq_vector,
   output logic             wake
);

   // ***********************************
   // Decode helpers
   // ***********************************
   function automatic logic [2:0] first_set(input logic [NSRC-1:0] v);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

   function automatic logic [11:0] vec_of(input logic [2:0] idx);
      return VEC_BASE + VEC_STEP * {9'h000, idx};
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction

   // ***********************************
   // Declarations
   // ***********************************
   logic [PSC_SEL_W-1:0] psc_q;
   logic [7:0]           tbc_q [2];
   logic [1:0]           tick_ovf;
   logic                 psc_tick;
   logic [7:0]           ien_q;
   logic [7:0]           ien_d;
   logic [NSRC-1:0]      flags_q;
   logic [NSRC-1:0]      flags_d;
   logic [NSRC-1:0]      hw_set;
   logic [NSRC-1:0]      pend;
   logic [2:0]           sel_q;
   logic                 take;
   logic                 gie;
   logic                 serial_any;
   logic                 uart_any;

   assign gie  = ien_q[IEN_GIE_BIT];
   assign take = irq_ack & irq_req;

   // ***********************************
   // Prescaler and time bases
   // ***********************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         psc_q <= PSC_RST[PSC_SEL_W-1:0];
      end else if (reg_wr && hit(reg_addr, ADDR_PSC)) begin
         psc_q <= reg_wdata[PSC_SEL_W-1:0];
      end
   end

   pitb_prescale u_psc (
      .core_clk (core_clk),
      .rstn     (rstn),
      .src_sel  (psc_q),
      .sub_clk  (sub_clk),
      .psc_tick (psc_tick)
   );

   for (genvar g = 0; g < 2; g++) begin : g_tb
      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            tbc_q[g] <= TBC_RST;
         end else if (reg_wr && hit(reg_addr, ADDR_TB0 + 8'(g))) begin
            // Unused bits are not stored and read back as zero
            tbc_q[g] <= {reg_wdata[TBC_RUN_BIT], 4'h0,
                         reg_wdata[PER_W-1:0]};
         end
      end

      pitb_tick #(
         .CNT_W (CNT_W)
      ) u_tick (
         .core_clk   (core_clk),
         .rstn       (rstn),
         .run        (tbc_q[g][TBC_RUN_BIT]),
         .period_sel (tbc_q[g][PER_W-1:0]),
         .psc_tick   (psc_tick),
         .ovf        (tick_ovf[g])
      );
   end

   // ***********************************
   // Request sources
   // ***********************************
   // serial events combined
   assign serial_any = serial_if_byte_evt | serial_if_match_evt |
                       serial_if_tmo_evt;
   assign uart_any   = |async_serial_evt;

   always_comb begin
      hw_set             = '0;
      hw_set[SRC_CONV]   = conv_done_evt;
      hw_set[SRC_TICK0]  = tick_ovf[0];
      hw_set[SRC_TICK1]  = tick_ovf[1];
      hw_set[SRC_SERIAL] = serial_any;
      hw_set[SRC_LOWV]   = low_supply_evt;
      hw_set[SRC_EEPROM] = eeprom_write_end_evt;
      hw_set[SRC_UART]   = uart_any;
   end

   // ***********************************
   // Request flags
   // ***********************************
   always_comb begin
      flags_d = flags_q;
      if (reg_wr && hit(reg_addr, ADDR_IFL)) begin
         // Software may also set a flag, which raises wake as an event would
         flags_d = reg_wdata[NSRC-1:0];
      end
      if (take) begin
         flags_d[sel_q] = 1'b0;
      end
      // flag holds otherwise, new events win over clears
      flags_d = flags_d | hw_set;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         flags_q <= IFL_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wake <= 1'b0;
      end else begin
         wake <= |(flags_d & ~flags_q);
      end
   end

   // ***********************************
   // Enables and global enable
   // ***********************************
   always_comb begin
      ien_d = ien_q;
      if (reg_wr && hit(reg_addr, ADDR_IEN)) begin
         ien_d = reg_wdata;
      end
      if (reti_exec) begin
         ien_d[IEN_GIE_BIT] = 1'b1;
      end
      if (take) begin
         ien_d[IEN_GIE_BIT] = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ien_q <= IEN_RST;
      end else begin
         ien_q <= ien_d;
      end
   end

   // ***********************************
   // Vectoring
   // ***********************************
   // all three conditions
   assign pend = flags_q & ien_q[NSRC-1:0] & {NSRC{gie}};

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_req    <= 1'b0;
         sel_q      <= 3'h0;
         irq_vector <= VEC_BASE;
      end else begin
         // Drop at once after a take so one request is never taken twice
         irq_req    <= (|pend) & ~stack_full & ~take;
         sel_q      <= first_set(pend);
         irq_vector <= vec_of(first_set(pend));
      end
   end

   // ***********************************
   // Register read port
   // ***********************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (!reg_rd) begin
         reg_rdata <= 8'h00;
      end else begin
         unique case (reg_addr)
            ADDR_PSC: reg_rdata <= {6'h00, psc_q};
            ADDR_TB0: reg_rdata <= tbc_q[0];
            ADDR_TB1: reg_rdata <= tbc_q[1];
            ADDR_IEN: reg_rdata <= ien_q;
            ADDR_IFL: reg_rdata <= {1'b0, flags_q};
            ADDR_VST: reg_rdata <= {irq_req, 4'h0, sel_q};
            default:  reg_rdata <= 8'h00;
         endcase
      end
   end

   // ***********************************
   // Checks
   // ***********************************
   property p_conv_set;
      @(posedge core_clk) disable iff (!rstn)
      conv_done_evt |=> flags_q[SRC_CONV];
   endproperty
   a_conv_set: assert property (p_conv_set)
      else $error("conversion end did not set flag");

   property p_vector;
      @(posedge core_clk) disable iff (!rstn)
      irq_req |-> $past(gie) && !$past(stack_full)
                  && $past(flags_q[first_set(pend)])
                  && $past(ien_q[first_set(pend)]);
   endproperty
   a_vector: assert property (p_vector)
      else $error("request raised without all enables");

   property p_svc_gie;
      @(posedge core_clk) disable iff (!rstn)
      take |=> !gie ##1 !irq_req;
   endproperty
   a_svc_gie: assert property (p_svc_gie)
      else $error("service left global enable set");

   property p_svc_flag;
      @(posedge core_clk) disable iff (!rstn)
      take && !hw_set[sel_q] && !reg_wr |=> !flags_q[$past(sel_q)];
   endproperty
   a_svc_flag: assert property (p_svc_flag)
      else $error("serviced flag not cleared");

   property p_tick_set;
      @(posedge core_clk) disable iff (!rstn)
      tick_ovf[1] |=> flags_q[SRC_TICK1];
   endproperty
   a_tick_set: assert property (p_tick_set)
      else $error("overflow did not set flag");

   property p_serial;
      @(posedge core_clk) disable iff (!rstn)
      serial_if_tmo_evt || serial_if_match_evt |=> flags_q[SRC_SERIAL];
   endproperty
   a_serial: assert property (p_serial)
      else $error("serial event lost");

   property p_uart;
      @(posedge core_clk) disable iff (!rstn)
      async_serial_evt != 6'h00 |=> flags_q[SRC_UART];
   endproperty
   a_uart: assert property (p_uart)
      else $error("uart event lost");

   property p_wake;
      @(posedge core_clk) disable iff (!rstn)
      ##1 ((flags_q & ~$past(flags_q)) != '0) |-> wake;
   endproperty
   a_wake: assert property (p_wake)
      else $error("rising flag gave no wake");

   property p_hold;
      @(posedge core_clk) disable iff (!rstn)
      flags_q[SRC_EEPROM] && !take && !reg_wr |=> flags_q[SRC_EEPROM];
   endproperty
   a_hold: assert property (p_hold)
      else $error("flag dropped without clear");

   property p_reti;
      @(posedge core_clk) disable iff (!rstn)
      reti_exec && !take |=> gie;
   endproperty
   a_reti: assert property (p_reti)
      else $error("return did not restore global enable");

   property p_prio;
      @(posedge core_clk) disable iff (!rstn)
      irq_req |-> ($past(pend) & ((7'h01 << sel_q) - 7'h01)) == 7'h00;
   endproperty
   a_prio: assert property (p_prio)
      else $error("lower vector was pending");

   c_take: cover property (@(posedge core_clk) disable iff (!rstn)
      take ##[1:20] reti_exec);
   c_stack: cover property (@(posedge core_clk) disable iff (!rstn)
      (|pend) && stack_full);
   c_tick: cover property (@(posedge core_clk) disable iff (!rstn)
      tick_ovf[0] ##1 wake);

endmodule // pitb_top

`default_nettype wire

// [tb/pitb_cpu_model.sv]
// Purpose : CPU core model taking offered interrupt vectors
// Assumes : irq_req and irq_vector are registered by the block
// Notes   : ack_dly 0 acks promptly, larger values ack slowly

`timescale 1ns/1ps
`default_nettype none

module pitb_cpu_model (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // Block side
   input  wire logic        irq_req,
   input  wire logic [11:0] irq_vector,
   output logic             irq_ack,
   // Bench side
   input  wire logic [3:0]  ack_dly,
   output logic      [11:0] taken_vec,
   output logic      [7:0]  taken_cnt
);
   // **********
   // Acknowledge
   // **********
   logic [3:0] wait_q;

   // Ack held one cycle; a dropped request loses the ack
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_ack   <= 1'b0;
         wait_q    <= 4'h0;
         taken_vec <= 12'h000;
         taken_cnt <= 8'h00;
      end else begin
         irq_ack <= 1'b0;
         if (irq_ack && irq_req) begin
            taken_vec <= irq_vector;
            taken_cnt <= taken_cnt + 8'h01;
            wait_q    <= 4'h0;
         end else if (irq_req && !irq_ack) begin
            if (wait_q >= ack_dly)
               irq_ack <= 1'b1;
            else
               wait_q <= wait_q + 4'h1;
         end else if (!irq_req) begin
            wait_q <= 4'h0;
         end
      end
   end
endmodule // pitb_cpu_model

`default_nettype wire

// [tb/tb_periph_irq_and_time_base.sv]
// Purpose : Self-checking bench for flags, vectoring and time bases
// Assumes : Sub clock rises every 8 core cycles
// Notes   : Periods compared by difference, hiding fixed latency

`timescale 1ns/1ps
`default_nettype none

module tb_periph_irq_and_time_base
   import pitb_pkg::*;
;
   logic        core_clk;
   logic        rstn;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic [11:0] ev;
   logic        sub_clk;
   logic        stack_full;
   logic        irq_ack;
   logic        reti_exec;
   logic        irq_req;
   logic [11:0] irq_vector;
   logic        wake;
   logic [3:0]  ack_dly;
   logic [11:0] taken_vec;
   logic [7:0]  taken_cnt;
   int          error_cnt = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          wake_cnt = 0;
   int          wake_cyc = 0;
   localparam int SRC_OF [12] = '{0, 3, 3, 3, 4, 5, 6, 6, 6, 6, 6, 6};
   localparam logic [7:0] MASK [3] = '{8'h03, 8'h87, 8'h87};

   pitb_top dut_u (
      .core_clk             (core_clk),
      .rstn                 (rstn),
      .reg_addr             (reg_addr),
      .reg_wdata            (reg_wdata),
      .reg_wr               (reg_wr),
      .reg_rd               (reg_rd),
      .reg_rdata            (reg_rdata),
      .conv_done_evt        (ev[0]),
      .serial_if_byte_evt   (ev[1]),
      .serial_if_match_evt  (ev[2]),
      .serial_if_tmo_evt    (ev[3]),
      .low_supply_evt       (ev[4]),
      .eeprom_write_end_evt (ev[5]),
      .async_serial_evt     (ev[11:6]),
      .sub_clk              (sub_clk),
      .stack_full           (stack_full),
      .irq_ack              (irq_ack),
      .reti_exec            (reti_exec),
      .irq_req              (irq_req),
      .irq_vector           (irq_vector),
      .wake                 (wake)
   );

   pitb_cpu_model cpu_u (
      .core_clk   (core_clk),
      .rstn       (rstn),
      .irq_req    (irq_req),
      .irq_vector (irq_vector),
      .irq_ack    (irq_ack),
      .ack_dly    (ack_dly),
      .taken_vec  (taken_vec),
      .taken_cnt  (taken_cnt)
   );

   // **********
   // Clocks and monitors
   // **********
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   initial begin
      sub_clk = 1'b0;
      forever begin
         repeat (4) @(posedge core_clk);
         sub_clk <= ~sub_clk;
      end
   end

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (wake === 1'b1) begin
         wake_cnt <= wake_cnt + 1;
         wake_cyc <= cyc + 1;
      end
   end

   initial begin
      #(50 * 60000);
      error_cnt++;
      $display("[FAIL] %0t watchdog expired", $time);
      complete_run();
   end

   // **********
   // Tasks
   // **********
   task automatic complete_run();
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   function automatic logic [11:0] vec(input int s);
      return VEC_BASE + VEC_STEP * 12'(s);
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1;
      chk(16'(reg_rdata), 16'(e));
   endtask

   task automatic reti();
      @(posedge core_clk);
      reti_exec <= 1'b1;
      @(posedge core_clk);
      reti_exec <= 1'b0;
   endtask

   task automatic wtake(input logic [11:0] e);
      int n;
      n = taken_cnt;
      for (int i = 0; i < 30 && taken_cnt == n; i++) @(posedge core_clk);
      #1;
      chk(16'(int'(taken_cnt) - n), 16'h0001);
      chk(16'(taken_vec), 16'(e));
   endtask

   // Cycles from enabling a unit to its wake pulse
   task automatic tmeas(input logic [7:0] a, input logic [7:0] c,
                        output int tm);
      int s;
      int n;
      wr(ADDR_IFL, 8'h00);
      wr(a, c);
      #1;
      s = cyc;
      n = wake_cnt;
      for (int i = 0; i < 40000 && wake_cnt == n; i++) begin
         @(posedge core_clk);
         #1;
      end
      tm = wake_cyc - s;
      wr(a, 8'h00);
   endtask

   // **********
   // Sequence
   // **********
   initial begin
      int n;
      int s;
      int t0;
      int t;
      logic [7:0] b;
      rstn       = 1'b0;
      reg_addr   = 8'h00;
      reg_wdata  = 8'h00;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      ev         = 12'h000;
      stack_full = 1'b0;
      reti_exec  = 1'b0;
      ack_dly    = 4'h0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      for (int a = 0; a < 5; a++) rdc(8'(a), 8'h00);
      foreach (MASK[i]) begin
         wr(8'(i), 8'hff);
         rdc(8'(i), MASK[i]);
         wr(8'(i), 8'h00);
      end
      for (int a = 5; a < 8; a += 2) begin
         wr(8'(a), 8'hff);
         rdc(8'(a), 8'h00);
      end
      // Every event input, disabled first, then serviced
      for (int k = 0; k < 12; k++) begin
         s = SRC_OF[k];
         b = 8'h01 << s;
         ack_dly <= k[0] ? 4'h3 : 4'h0;
         n = wake_cnt;
         @(posedge core_clk);
         ev <= 12'h001 << k;
         @(posedge core_clk);
         ev <= 12'h000;
         repeat (3) @(posedge core_clk);
         #1;
         chk(16'(wake_cnt - n), 16'h0001);
         chk(16'(irq_req), 16'h0000);
         rdc(ADDR_IFL, b);
         wr(ADDR_IEN, 8'h80 | b);
         wtake(vec(s));
         rdc(ADDR_IFL, 8'h00);
         rdc(ADDR_IEN, b);
         reti();
         rdc(ADDR_IEN, 8'h80 | b);
         wr(ADDR_IEN, 8'h00);
      end
      // Stack full holds off, then lowest index first
      @(posedge core_clk);
      stack_full <= 1'b1;
      wr(ADDR_IFL, 8'h52);
      wr(ADDR_IEN, 8'hd2);
      repeat (6) @(posedge core_clk);
      #1;
      chk(16'(irq_req), 16'h0000);
      rdc(ADDR_VST, 8'(SRC_TICK0));
      @(posedge core_clk);
      stack_full <= 1'b0;
      wtake(vec(SRC_TICK0));
      reti();
      wtake(vec(SRC_LOWV));
      reti();
      wtake(vec(SRC_UART));
      rdc(ADDR_IFL, 8'h00);
      wr(ADDR_IEN, 8'h00);
      // Time base periods and prescaler sources
      tmeas(ADDR_TB0, 8'h80, t0);
      rdc(ADDR_IFL, 8'h02);
      tmeas(ADDR_TB0, 8'h81, t);
      chk(16'(t - t0), 16'h0100);
      tmeas(ADDR_TB1, 8'h80, t);
      rdc(ADDR_IFL, 8'h04);
      chk(16'(t), 16'(t0));
      tmeas(ADDR_TB1, 8'h87, t);
      chk(16'(t - t0), 16'h7f00);
      wr(ADDR_PSC, 8'h01);
      tmeas(ADDR_TB0, 8'h80, t);
      chk(16'(t - t0 > 762 && t - t0 < 774), 16'h0001);
      for (int p = 2; p < 4; p++) begin
         wr(ADDR_PSC, 8'(p));
         tmeas(ADDR_TB0, 8'h80, t);
         chk(16'(t - t0 > 1774 && t - t0 < 1810), 16'h0001);
      end
      wr(ADDR_PSC, 8'h00);
      wr(ADDR_IFL, 8'h00);
      repeat (600) @(posedge core_clk);
      rdc(ADDR_IFL, 8'h00);
      complete_run();
   end
endmodule // tb_periph_irq_and_time_base

`default_nettype wire
